/* File: cca_pkg.sv */
package cca_pkg;

  // ****************************************************
  // Geometry
  // ****************************************************
  localparam int          NMOD  = 5;
  localparam int          AW    = 8;
  localparam int          DW    = 8;
  localparam int          CW    = 16;

  // ****************************************************
  // Register offsets on the plain register port
  // ****************************************************
  localparam logic [7:0]  A_CTRL   = 8'hD8;  // array_control_reg
  localparam logic [7:0]  A_MODE0  = 8'hDA;  // module_mode_reg 0..4
  localparam logic [7:0]  A_CNTL   = 8'hE9;  // counter_low_byte
  localparam logic [7:0]  A_CNTH   = 8'hF9;  // counter_high_byte
  localparam logic [7:0]  A_CMPL0  = 8'hEA;  // module_compare_low 0..4
  localparam logic [7:0]  A_CMPH0  = 8'hFA;  // module_compare_high 0..4
  localparam logic [7:0]  A_PINLAT = 8'hC0;  // General-purpose pin latch
  localparam logic [7:0]  A_PINDIR = 8'hC1;  // General-purpose pin direction
  localparam logic [7:0]  A_PININ  = 8'hC2;  // Synchronised pin levels

  // ****************************************************
  // Field positions
  // ****************************************************
  localparam int          B_OVF    = 7;  // Counter overflow flag
  localparam int          B_RUN    = 6;  // counter_run_bit
  localparam int          B_CMPEN  = 6;  // compare_enable_bit
  localparam int          B_RISE   = 5;  // rising_capture_select
  localparam int          B_FALL   = 4;  // falling_capture_select
  localparam int          B_MATCH  = 3;  // match_flag_enable
  localparam int          B_TOG    = 2;  // toggle_on_match
  localparam int          B_PWM    = 1;  // pulse_width_select
  localparam int          B_IRQEN  = 0;  // module_irq_enable

  // ****************************************************
  // Reset values and counter constants
  // ****************************************************
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_CNT  = 16'h0000;
  localparam logic [7:0]  LOW_MAX  = 8'hFF;
  localparam logic [15:0] CNT_ONE  = 16'h0001;
  localparam logic [15:0] CNT_MAX  = 16'hFFFF;

  // ****************************************************
  // Carriers
  // ****************************************************
  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic          wr;
    logic          rd;
  } cca_req_s;

endpackage

/* File: cca_top.sv */
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - Each module independently capture, compare or off
// - Modules act only while counter runs
// - Events set module flag; enabled flag interrupts
// - Compare registers readable and writable any time; a capture in the same cycle wins over the write
// - Edge selects pick rising, falling or both
// - Selected edge copies counter, sets flag
// - Flags cleared only by software
// - New capture overwrites previous captured value
// - Timer and toggle modes compare 16 bits
// - Pulse-width mode compares counter low byte
// - Compare evaluated at every counter tick
// - Compare enable bit selects compare function
// - Timer mode match sets event flag
// - Low write clears, high write sets enable
// - Toggle mode match inverts pin, sets flag
// - Last software pin level sets toggle direction
// - Unchanged compare toggles again after wrap
// - Unused module pins act as port pins
module cca_top (
  input  wire logic                        CLK,
  input  wire logic                        RST_N,
  input  wire logic [cca_pkg::AW-1:0]      ADDR,
  input  wire logic [cca_pkg::DW-1:0]      WDATA,
  input  wire logic                        WR,
  input  wire logic                        RD,
  output var  logic [cca_pkg::DW-1:0]      RDATA,
  input  wire logic [cca_pkg::NMOD-1:0]    CEX_IN,
  output var  logic [cca_pkg::NMOD-1:0]    CEX_OUT,
  output var  logic [cca_pkg::NMOD-1:0]    CEX_OE,
  output var  logic                        IRQ
);

  // ****************************************************
  // Storage
  // ****************************************************
  cca_pkg::cca_req_s              req;
  logic [cca_pkg::CW-1:0]         cnt_r;
  logic                           run_r;
  logic                           ovf_r;
  logic [cca_pkg::NMOD-1:0]       flag_r;
  logic [cca_pkg::DW-1:0]         mode_r  [cca_pkg::NMOD];
  logic [cca_pkg::DW-1:0]         cmpl_r  [cca_pkg::NMOD];
  logic [cca_pkg::DW-1:0]         cmph_r  [cca_pkg::NMOD];
  logic [cca_pkg::NMOD-1:0]       lat_r;
  logic [cca_pkg::NMOD-1:0]       dir_r;
  logic [cca_pkg::NMOD-1:0]       pwm_r;
  logic [cca_pkg::NMOD-1:0]       s1_r;
  logic [cca_pkg::NMOD-1:0]       s2_r;
  logic [cca_pkg::NMOD-1:0]       prev_r;
  logic [cca_pkg::NMOD-1:0]       cap_ev;
  logic [cca_pkg::NMOD-1:0]       hit_ev;
  logic [cca_pkg::NMOD-1:0]       tog_ev;
  logic [cca_pkg::NMOD-1:0]       pwm_mode;
  logic [cca_pkg::NMOD-1:0]       lo_wr;
  logic [cca_pkg::NMOD-1:0]       hi_wr;
  logic [cca_pkg::NMOD-1:0]       md_wr;
  logic                           wrap;
  logic                           lo_wrap;
  logic [cca_pkg::DW-1:0]         rd_nxt;

  // Address match of a per-module register, used by both decoders
  function automatic logic hit(input logic [7:0] a, input logic [7:0] base,
                               input int i);
    hit = (a == base + 8'(i));
  endfunction

  // Low and high bytes of a count, shared by capture, PWM and the read path
  function automatic logic [cca_pkg::DW-1:0] lo_byte(input logic [cca_pkg::CW-1:0] v);
    lo_byte = v[cca_pkg::DW-1:0];
  endfunction

  function automatic logic [cca_pkg::DW-1:0] hi_byte(input logic [cca_pkg::CW-1:0] v);
    hi_byte = v[cca_pkg::CW-1:cca_pkg::DW];
  endfunction

  // Write strobe aimed at one shared register
  function automatic logic wr_at(input cca_pkg::cca_req_s r, input logic [7:0] a);
    wr_at = r.wr && (r.addr == a);
  endfunction

  // Pack of the register port
  assign req.addr  = ADDR;
  assign req.wdata = WDATA;
  assign req.wr    = WR;
  assign req.rd    = RD;

  // ****************************************************
  // Write decode and event detection
  // ****************************************************
  // Counter wraps once per full count; low byte wrap ends a PWM period
  assign wrap    = run_r && (cnt_r == cca_pkg::CNT_MAX);
  assign lo_wrap = run_r && (lo_byte(cnt_r) == cca_pkg::LOW_MAX);

  always_comb begin
    for (int i = 0; i < cca_pkg::NMOD; i++) begin
      lo_wr[i] = req.wr && hit(req.addr, cca_pkg::A_CMPL0, i);
      hi_wr[i] = req.wr && hit(req.addr, cca_pkg::A_CMPH0, i);
      md_wr[i] = req.wr && hit(req.addr, cca_pkg::A_MODE0, i);
      // Edge seen between synchronised and delayed copy
      cap_ev[i] = run_r && !mode_r[i][cca_pkg::B_CMPEN] &&
                  ((mode_r[i][cca_pkg::B_RISE] && s2_r[i] && !prev_r[i]) ||
                   (mode_r[i][cca_pkg::B_FALL] && !s2_r[i] && prev_r[i]));
      // Full 16-bit match, evaluated on every counter tick
      hit_ev[i] = run_r && mode_r[i][cca_pkg::B_CMPEN] &&
                  mode_r[i][cca_pkg::B_MATCH] &&
                  ({cmph_r[i], cmpl_r[i]} == cnt_r);
      tog_ev[i] = hit_ev[i] && mode_r[i][cca_pkg::B_TOG];
      // PWM owns the pin only while compare enable is set as well
      pwm_mode[i] = mode_r[i][cca_pkg::B_CMPEN] && mode_r[i][cca_pkg::B_PWM];
    end
  end

  // ****************************************************
  // Shared counter and run control
  // ****************************************************
  // Counter only writable while stopped, so a running time base is never torn
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cnt_r <= cca_pkg::RST_CNT;
    end else if (run_r) begin
      cnt_r <= cnt_r + cca_pkg::CNT_ONE;
    end else if (wr_at(req, cca_pkg::A_CNTL)) begin
      cnt_r[cca_pkg::DW-1:0] <= req.wdata;
    end else if (wr_at(req, cca_pkg::A_CNTH)) begin
      cnt_r[cca_pkg::CW-1:cca_pkg::DW] <= req.wdata;
    end
  end

  // Run bit and overflow flag; a wrap beats a software clear
  // Stopping the count freezes every module, since no event can fire
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      run_r <= 1'b0;
      ovf_r <= 1'b0;
    end else begin
      if (wr_at(req, cca_pkg::A_CTRL)) begin
        run_r <= req.wdata[cca_pkg::B_RUN];
        ovf_r <= (ovf_r && req.wdata[cca_pkg::B_OVF]) || wrap;
      end else begin
        ovf_r <= ovf_r || wrap;
      end
    end
  end

  // ****************************************************
  // Module event flags
  // ****************************************************
  // Hardware only sets; writing zero clears, and a same-cycle event wins
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      flag_r <= '0;
    end else if (wr_at(req, cca_pkg::A_CTRL)) begin
      flag_r <= (flag_r & req.wdata[cca_pkg::NMOD-1:0]) | cap_ev | hit_ev;
    end else begin
      flag_r <= flag_r | cap_ev | hit_ev;
    end
  end

  // ****************************************************
  // Mode and compare registers
  // ****************************************************
  // Low write drops compare enable, high write restores it
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < cca_pkg::NMOD; i++) begin
        mode_r[i] <= cca_pkg::RST_BYTE;
      end
    end else begin
      for (int i = 0; i < cca_pkg::NMOD; i++) begin
        if (md_wr[i]) begin
          mode_r[i] <= req.wdata;
        end else if (lo_wr[i]) begin
          mode_r[i][cca_pkg::B_CMPEN] <= 1'b0;
        end else if (hi_wr[i]) begin
          mode_r[i][cca_pkg::B_CMPEN] <= 1'b1;
        end
      end
    end
  end

  // Capture overwrites; otherwise software and PWM reload own the pair
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < cca_pkg::NMOD; i++) begin
        cmpl_r[i] <= cca_pkg::RST_BYTE;
        cmph_r[i] <= cca_pkg::RST_BYTE;
      end
    end else begin
      for (int i = 0; i < cca_pkg::NMOD; i++) begin
        if (cap_ev[i]) begin
          cmpl_r[i] <= lo_byte(cnt_r);
          cmph_r[i] <= hi_byte(cnt_r);
        end else begin
          if (lo_wr[i]) begin
            cmpl_r[i] <= req.wdata;
          end else if (pwm_mode[i] && lo_wrap) begin
            cmpl_r[i] <= cmph_r[i];
          end
          if (hi_wr[i]) begin
            cmph_r[i] <= req.wdata;
          end
        end
      end
    end
  end

  // ****************************************************
  // Pins
  // ****************************************************
  // Two-stage synchroniser, third stage only for edge history
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      s1_r   <= '0;
      s2_r   <= '0;
      prev_r <= '0;
    end else begin
      s1_r   <= CEX_IN;
      s2_r   <= s1_r;
      prev_r <= s2_r;
    end
  end

  // Toggle flips the software latch, so the last written level sets direction
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      lat_r <= '0;
      dir_r <= '0;
    end else begin
      if (wr_at(req, cca_pkg::A_PINDIR)) begin
        dir_r <= req.wdata[cca_pkg::NMOD-1:0];
      end
      if (wr_at(req, cca_pkg::A_PINLAT)) begin
        lat_r <= req.wdata[cca_pkg::NMOD-1:0] ^ tog_ev;
      end else begin
        lat_r <= lat_r ^ tog_ev;
      end
    end
  end

  // PWM output: high from low-byte match until the low byte rolls over
  // Limitation: a duty value of FF never rises, as the rollover clear wins
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pwm_r <= '0;
    end else begin
      for (int i = 0; i < cca_pkg::NMOD; i++) begin
        if (!pwm_mode[i] || lo_wrap) begin
          pwm_r[i] <= 1'b0;
        end else if (run_r && lo_byte(cnt_r) == cmpl_r[i]) begin
          pwm_r[i] <= 1'b1;
        end
      end
    end
  end

  // Pin drive: PWM owns the pin, otherwise the latch as a port pin
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      CEX_OUT <= '0;
      CEX_OE  <= '0;
    end else begin
      for (int i = 0; i < cca_pkg::NMOD; i++) begin
        if (pwm_mode[i]) begin
          CEX_OUT[i] <= pwm_r[i];
          CEX_OE[i]  <= 1'b1;
        end else begin
          CEX_OUT[i] <= lat_r[i] ^ tog_ev[i];
          // Toggle mode drives the pin even before its first match
          CEX_OE[i]  <= dir_r[i] | tog_ev[i] |
                        (mode_r[i][cca_pkg::B_TOG] & mode_r[i][cca_pkg::B_CMPEN]);
        end
      end
    end
  end

  // ****************************************************
  // Interrupt request
  // ****************************************************
  // Level request while any enabled flag stands
  // Event term lets the request rise with the flag rather than a cycle late
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= 1'b0;
      for (int i = 0; i < cca_pkg::NMOD; i++) begin
        if ((flag_r[i] || cap_ev[i] || hit_ev[i]) && mode_r[i][cca_pkg::B_IRQEN]) begin
          IRQ <= 1'b1;
        end
      end
    end
  end

  // ****************************************************
  // Read path
  // ****************************************************
  // Unmapped addresses read zero
  always_comb begin
    rd_nxt = cca_pkg::RST_BYTE;
    case (req.addr)
      cca_pkg::A_CTRL:   rd_nxt = {ovf_r, run_r, 1'b0, flag_r};
      cca_pkg::A_CNTL:   rd_nxt = lo_byte(cnt_r);
      cca_pkg::A_CNTH:   rd_nxt = hi_byte(cnt_r);
      cca_pkg::A_PINLAT: rd_nxt = {3'h0, lat_r};
      cca_pkg::A_PINDIR: rd_nxt = {3'h0, dir_r};
      cca_pkg::A_PININ:  rd_nxt = {3'h0, s2_r};
      default:           rd_nxt = cca_pkg::RST_BYTE;
    endcase
    // Per-module registers decode after the shared ones and take precedence
    for (int i = 0; i < cca_pkg::NMOD; i++) begin
      if (hit(req.addr, cca_pkg::A_MODE0, i)) begin
        rd_nxt = mode_r[i];
      end
      if (hit(req.addr, cca_pkg::A_CMPL0, i)) begin
        rd_nxt = cmpl_r[i];
      end
      if (hit(req.addr, cca_pkg::A_CMPH0, i)) begin
        rd_nxt = cmph_r[i];
      end
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA <= cca_pkg::RST_BYTE;
    end else if (req.rd) begin
      RDATA <= rd_nxt;
    end else begin
      RDATA <= cca_pkg::RST_BYTE;
    end
  end

endmodule

`default_nettype wire

/* File: cca_chk.sv */
`timescale 1ns/1ns
`default_nettype none
module cca_chk (
  input  wire logic                     CLK,
  input  wire logic                     RST_N,
  input  wire logic [cca_pkg::AW-1:0]   ADDR,
  input  wire logic [cca_pkg::DW-1:0]   WDATA,
  input  wire logic                     WR,
  input  wire logic                     RD,
  input  wire logic [cca_pkg::DW-1:0]   RDATA,
  input  wire logic [cca_pkg::NMOD-1:0] CEX_IN,
  input  wire logic [cca_pkg::NMOD-1:0] CEX_OUT,
  input  wire logic [cca_pkg::NMOD-1:0] CEX_OE,
  input  wire logic                     IRQ
);
  logic run_r;
  logic cnt_rd;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // Shadow run bit: nothing may move by itself while it is clear
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N)
      run_r <= 1'b0;
    else if (WR && ADDR == cca_pkg::A_CTRL)
      run_r <= WDATA[cca_pkg::B_RUN];
  end
  // Back-to-back low-count reads expose every tick
  assign cnt_rd = RD && ADDR == cca_pkg::A_CNTL;
  rdata_idle_a: assert property (!$past(RD) |-> RDATA == 8'h00)
    else $error("read data outside read slot");
  ctrl_resv_a: assert property (RD && ADDR == cca_pkg::A_CTRL |=> !RDATA[5])
    else $error("reserved control bit set");
  count_tick_a: assert property (run_r && cnt_rd ##1 cnt_rd |=>
    RDATA == $past(RDATA) + 8'h01) else $error("counter missed a tick");
  count_hold_a: assert property (!run_r && cnt_rd ##1 cnt_rd |=> $stable(RDATA))
    else $error("counter moved while stopped");
  pin_quiet_a: assert property ($changed(CEX_OUT) |->
    $past(run_r) || $past(run_r, 2) || $past(WR) || $past(WR, 2)) else $error("pin moved idle");
  oe_quiet_a: assert property ($changed(CEX_OE) |->
    $past(run_r) || $past(run_r, 2) || $past(WR) || $past(WR, 2)) else $error("enable moved idle");
  irq_fall_a: assert property ($fell(IRQ) |-> $past(WR) || $past(WR, 2))
    else $error("irq dropped without software");
  irq_rise_a: assert property ($rose(IRQ) |->
    $past(run_r) || $past(run_r, 2) || $past(WR) || $past(WR, 2)) else $error("irq rose idle");
  irq_seen_c: cover property ($rose(IRQ));
  tog_seen_c: cover property ($changed(CEX_OUT) && run_r);
  tick_seen_c: cover property (run_r && cnt_rd ##1 cnt_rd);
endmodule
`default_nettype wire

/* File: cca_pin_model.sv */
`timescale 1ns/1ns
`default_nettype none
module cca_pin_model (
  input  wire logic [cca_pkg::NMOD-1:0] pin_out,
  input  wire logic [cca_pkg::NMOD-1:0] pin_oe,
  input  wire logic [cca_pkg::NMOD-1:0] src_lvl,
  input  wire logic [cca_pkg::NMOD-1:0] src_en,
  output logic      [cca_pkg::NMOD-1:0] pin_lvl
);
  // Device drive wins, then an enabled source; otherwise the pull-up, never its old value
  always_comb begin
    for (int i = 0; i < cca_pkg::NMOD; i++) begin
      if (pin_oe[i])
        pin_lvl[i] = pin_out[i];
      else if (src_en[i])
        pin_lvl[i] = src_lvl[i];
      else
        pin_lvl[i] = 1'b1;
    end
  end
endmodule
`default_nettype wire

/* File: cca_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module cca_tb_top;
  logic                     clk, rst_n, wr, rd, irq;
  logic [7:0]               addr, wdata, rdata;
  logic [cca_pkg::NMOD-1:0] pin_lvl, cex_out, cex_oe, src_lvl, src_en;
  logic [7:0]               cap_modes [3] = '{8'h21, 8'h10, 8'h31};
  logic [7:0]               cmp_modes [3] = '{8'h49, 8'h48, 8'h00};
  int                       err_count, total_checks, cyc, k_run, m;
  cca_top cca_top_inst (.CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .CEX_IN(pin_lvl), .CEX_OUT(cex_out), .CEX_OE(cex_oe), .IRQ(irq));
  cca_pin_model cca_pin_model_inst (.pin_out(cex_out), .pin_oe(cex_oe), .src_lvl(src_lvl),
    .src_en(src_en), .pin_lvl(pin_lvl));
  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Cycle count doubles as the hang guard; the wrap test alone needs about 66k
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      err_count++;
      close_out();
    end
  end
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    chk8(nm, {7'h00, e}, {7'h00, g});
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Register port cycles: one-cycle strobes (rd_twice holds its read strobe two cycles), data taken in the slot after
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask
  task automatic rd_twice(output logic [7:0] v1, output logic [7:0] v2);
    @(posedge clk);
    addr <= cca_pkg::A_CNTL;
    rd <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    v1 = rdata;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v2 = rdata;
  endtask
  // Counter parked on the compare value: must stay silent until run is set
  task automatic cmp_run(input logic [7:0] md, input logic [7:0] n, input logic lvl);
    logic [7:0] f;
    wr_reg(cca_pkg::A_CTRL, 8'h00);
    wr_reg(cca_pkg::A_CNTL, n);
    wr_reg(cca_pkg::A_CNTH, 8'h00);
    wr_reg(cca_pkg::A_PINLAT, 8'(lvl) << m);
    wr_reg(cca_pkg::A_CMPL0 + 8'(m), n);
    wr_reg(cca_pkg::A_CMPH0 + 8'(m), 8'h00);
    wr_reg(cca_pkg::A_MODE0 + 8'(m), md);
    rd_reg(cca_pkg::A_CTRL, f);
    chk1("flag_stopped", 1'b0, f[m]);
    wr_reg(cca_pkg::A_CTRL, 8'h40);
    repeat (8) @(posedge clk);
    rd_reg(cca_pkg::A_CTRL, f);
    chk1("match_flag", md[6] & md[3], f[m]);
    chk1("match_irq", md[6] & md[3] & md[0], irq);
    chk1("match_pin", md[2] ? ~lvl : lvl, cex_out[m]);
    chk1("match_oe", md[2], cex_oe[m]);
  endtask
  // One pin edge; captured value must fall just after the edge in counter time
  task automatic cap_edge(input logic [7:0] md, input logic lv);
    logic [7:0] f, lo, hi;
    int         kp;
    wr_reg(cca_pkg::A_CTRL, 8'h40);
    src_lvl[m] <= lv;
    kp = cyc - k_run;
    repeat (6) @(posedge clk);
    rd_reg(cca_pkg::A_CTRL, f);
    chk1("cap_flag", lv ? md[5] : md[4], f[m]);
    chk1("cap_irq", (lv ? md[5] : md[4]) & md[0], irq);
    rd_reg(cca_pkg::A_CMPL0 + 8'(m), lo);
    rd_reg(cca_pkg::A_CMPH0 + 8'(m), hi);
    if (lv ? md[5] : md[4])
      chk1("cap_time", 1'b1, (int'({hi, lo}) - kp) inside {[-1:8]});
  endtask
  initial begin
    logic [7:0] v1, v2, d1, d2;
    int         n;
    {addr, wdata, wr, rd, src_lvl, rst_n} = '0;
    {cyc, err_count, total_checks, k_run} = '0;
    src_en = '1;
    void'($urandom(32'h7ed4));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(cca_pkg::A_CTRL, v1);
    chk8("ctrl_reset", 8'h00, v1);
    rd_reg(8'h00, v1);
    chk8("unmapped", 8'h00, v1);
    rd_twice(v1, v2);
    chk8("cnt_hold", v1, v2);
    wr_reg(cca_pkg::A_CTRL, 8'h40);
    rd_twice(v1, v2);
    chk8("cnt_tick", v1 + 8'h01, v2);
    // Compare registers stay writable with the counter running
    for (int i = 0; i < cca_pkg::NMOD; i++) begin
      d1 = 8'($urandom);
      d2 = 8'($urandom);
      wr_reg(cca_pkg::A_MODE0 + 8'(i), 8'h48);
      wr_reg(cca_pkg::A_CMPL0 + 8'(i), d1);
      rd_reg(cca_pkg::A_MODE0 + 8'(i), v1);
      chk8("mode_low_wr", 8'h08, v1);
      wr_reg(cca_pkg::A_CMPH0 + 8'(i), d2);
      rd_reg(cca_pkg::A_MODE0 + 8'(i), v1);
      chk8("mode_high_wr", 8'h48, v1);
      rd_reg(cca_pkg::A_CMPL0 + 8'(i), v1);
      chk8("cmp_low", d1, v1);
      rd_reg(cca_pkg::A_CMPH0 + 8'(i), v1);
      chk8("cmp_high", d2, v1);
    end
    m = $urandom_range(4);
    wr_reg(cca_pkg::A_CTRL, 8'h00);
    wr_reg(cca_pkg::A_CNTL, 8'h00);
    wr_reg(cca_pkg::A_CNTH, 8'h00);
    wr_reg(cca_pkg::A_CTRL, 8'h40);
    k_run = cyc;
    foreach (cap_modes[j]) begin
      wr_reg(cca_pkg::A_MODE0 + 8'(m), cap_modes[j]);
      cap_edge(cap_modes[j], 1'b1);
      cap_edge(cap_modes[j], 1'b0);
    end
    // PWM: pin low below the duty value, high after it within one period
    wr_reg(cca_pkg::A_CTRL, 8'h00);
    wr_reg(cca_pkg::A_CNTL, 8'h00);
    wr_reg(cca_pkg::A_CMPL0 + 8'(m), 8'h80);
    wr_reg(cca_pkg::A_CMPH0 + 8'(m), 8'h80);
    wr_reg(cca_pkg::A_MODE0 + 8'(m), 8'h42);
    wr_reg(cca_pkg::A_CTRL, 8'h40);
    repeat (64) @(posedge clk);
    @(negedge clk);
    chk1("pwm_low", 1'b0, cex_out[m]);
    chk1("pwm_oe", 1'b1, cex_oe[m]);
    repeat (128) @(posedge clk);
    @(negedge clk);
    chk1("pwm_high", 1'b1, cex_out[m]);
    foreach (cmp_modes[j])
      cmp_run(cmp_modes[j], 8'($urandom_range(10, 60)), 1'b0);
    n = $urandom_range(10, 60);
    cmp_run(8'h4D, 8'(n), 1'b0);
    repeat (20) @(posedge clk);
    rd_reg(cca_pkg::A_CTRL, v1);
    chk1("flag_kept", 1'b1, v1[m]);
    wr_reg(cca_pkg::A_CTRL, 8'h40);
    rd_reg(cca_pkg::A_CTRL, v1);
    chk1("flag_clr", 1'b0, v1[m]);
    chk1("irq_clr", 1'b0, irq);
    cmp_run(8'h4D, 8'(n), 1'b1);
    // First match came at start, so the next one needs a full 65536-tick wrap
    repeat (65500) @(posedge clk);
    @(negedge clk);
    chk1("no_early", 1'b0, cex_out[m]);
    repeat (80) @(posedge clk);
    @(negedge clk);
    chk1("wrap_tog", 1'b1, cex_out[m]);
    close_out();
  end
endmodule
bind cca_top cca_chk cca_chk_inst (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA),
  .WR(WR), .RD(RD), .RDATA(RDATA), .CEX_IN(CEX_IN), .CEX_OUT(CEX_OUT), .CEX_OE(CEX_OE),
  .IRQ(IRQ));
`default_nettype wire
